/* File: logic/pad_ctrl_defines.vh */
// register map, reset values and field constants for the port pad control
`ifndef PAD_CTRL_DEFINES_VH
`define PAD_CTRL_DEFINES_VH

// port width and register bus widths
`define PAD_W          8
`define PAD_AW         4

// register indices on the plain register port
`define OFS_DIRECTION  4'h0
`define OFS_OUT_DATA   4'h1
`define OFS_READBACK   4'h2
`define OFS_IBE        4'h3
`define OFS_PULLUP     4'h4
`define OFS_OPEN_DRAIN 4'h5
`define OFS_PIN_FUNC   4'h6
`define OFS_MODE       4'h7

// reset values
`define RST_BYTE       8'h00
`define RST_MODE       2'h0

// mode register fields
`define MODE_HW_STBY   0
`define MODE_SW_STBY   1

// implemented-bit masks for eight, six and four pin ports
`define MASK_8PIN      8'hff
`define MASK_6PIN      8'h3f
`define MASK_4PIN      8'h0f

// value a gated input is held at
`define IN_FORCED      1'b1

`endif

/* File: logic/pad_pin_cell.v */
// one pin: output priority, open-drain, pull-up gating and input gating
`timescale 1ns/1ps
`include "pad_ctrl_defines.vh"

module pad_pin_cell
(
    input  wire pin_in,
    input  wire ibe,
    input  wire pue,
    input  wire ods,
    input  wire dir,
    input  wire dout,
    input  wire bus_oe,
    input  wire bus_out,
    input  wire p1_oe,
    input  wire p1_out,
    input  wire p2_oe,
    input  wire p2_out,
    input  wire pfs,
    input  wire hw_stby,
    output reg  out_nxt,
    output reg  oe_n_nxt,
    output wire pullup_nxt,
    output wire in_a_nxt,
    output wire in_b_nxt,
    output wire drives
);

    wire gated_in;
    reg  drv_en;
    reg  drv_val;

    // source select: bus, first peripheral, second peripheral, then port
    always @*
    begin
        drv_en  = 1'b1;
        drv_val = dout;
        if (bus_oe)
            drv_val = bus_out;
        else if (p1_oe)
            drv_val = p1_out;
        else if (p2_oe)
            drv_val = p2_out;
        else
            drv_en = dir;
    end

    // open-drain releases the pin on a one; push-pull drives both levels
    always @*
    begin
        out_nxt  = drv_val;
        oe_n_nxt = ~drv_en;
        if (ods && drv_val)
            oe_n_nxt = 1'b1;
        if (ods)
            out_nxt = 1'b0;
    end

    assign drives = drv_en;

    // pull-up only on an input pin outside hardware standby
    assign pullup_nxt = pue & ~drv_en & ~hw_stby;

    // disabled buffer holds the inward signal high
    assign gated_in = ibe ? pin_in : `IN_FORCED;

    // pin function select routes the input to the a or b assignment
    assign in_a_nxt = pfs ? `IN_FORCED : gated_in;
    assign in_b_nxt = pfs ? gated_in : `IN_FORCED;

endmodule

/* File: logic/port_pad_buffer_control.v */
// pad control for one general-purpose port: registers, pins and routing
//
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "pad_ctrl_defines.vh"

////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - enabled buffer passes pin, disabled forces high
// - disabled buffer hides pin from peripherals
// - readback shows pin level regardless of buffer enable
// - buffer change may glitch; software masks edge
// - buffer enable register eight bits, resets zero
// - six/four pin ports keep upper bits reserved
// - pull-up register only on pull-up ports, resets zero
// - pull-up on for input pin with bit set
// - pull-up off in reset, hardware standby, any output
// - software standby and normal follow pull-up bit
// - open-drain bit one gives NMOS open drain
// - open-drain register eight bits, resets zero
// - peripheral output enables mark valid outputs
// - upper pins: direction one output, zero input
// - pin function select moves a/b assignments
// - direction bit one output, zero input
// - readback: output data if output, else pin
// - bus enable wins, then first peripheral; direction last
module port_pad_buffer_control
#(
    parameter [7:0] IMPL_MASK  = `MASK_8PIN,
    parameter       HAS_PULLUP = 1,
    parameter       HAS_ODR    = 1
)
(
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [3:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [7:0]  reg_rdata,
    input  wire [7:0]  pad_in,
    output reg  [7:0]  pad_out,
    output reg  [7:0]  pad_oe_n,
    output reg  [7:0]  pullup_on,
    input  wire [7:0]  bus_oe,
    input  wire [7:0]  bus_out,
    input  wire [7:0]  periph1_oe,
    input  wire [7:0]  periph1_out,
    input  wire [7:0]  periph2_oe,
    input  wire [7:0]  periph2_out,
    output reg  [7:0]  periph_in_a,
    output reg  [7:0]  periph_in_b,
    output reg  [7:0]  pin_drives,
    output reg         hw_standby,
    output reg         sw_standby
);

    ////////////////////////////////////////////////////////////////////
    // control registers

    reg  [7:0] direction_bits_r;
    reg  [7:0] output_data_bits_r;
    reg  [7:0] input_buffer_enable_r;
    reg  [7:0] pullup_enable_r;
    reg  [7:0] open_drain_select_r;
    reg  [7:0] pin_function_select_r;
    reg  [1:0] mode_r;

    // mode fields by name, so no bit position hides in the logic
    wire       hw_stby_sel;
    wire       sw_stby_sel;

    assign hw_stby_sel = mode_r[`MODE_HW_STBY];
    assign sw_stby_sel = mode_r[`MODE_SW_STBY];

    // masks that hide unimplemented bits and absent registers
    wire [7:0] pu_mask;
    wire [7:0] od_mask;

    assign pu_mask = (HAS_PULLUP != 0) ? IMPL_MASK : `RST_BYTE;
    assign od_mask = (HAS_ODR != 0) ? IMPL_MASK : `RST_BYTE;

    // masked views: reserved pins and absent registers stay at zero
    wire [7:0] dir_view;
    wire [7:0] dat_view;
    wire [7:0] ibe_view;
    wire [7:0] pue_view;
    wire [7:0] ods_view;
    wire [7:0] pfs_view;

    assign dir_view = direction_bits_r & IMPL_MASK;
    assign dat_view = output_data_bits_r & IMPL_MASK;
    assign ibe_view = input_buffer_enable_r & IMPL_MASK;
    assign pue_view = pullup_enable_r & pu_mask;
    assign ods_view = open_drain_select_r & od_mask;
    assign pfs_view = pin_function_select_r & IMPL_MASK;

    // per-register write strobes
    wire wr_dir;
    wire wr_dat;
    wire wr_ibe;
    wire wr_pue;
    wire wr_ods;
    wire wr_pfs;
    wire wr_mode;

    assign wr_dir  = reg_wr && (reg_addr == `OFS_DIRECTION);
    assign wr_dat  = reg_wr && (reg_addr == `OFS_OUT_DATA);
    assign wr_ibe  = reg_wr && (reg_addr == `OFS_IBE);
    assign wr_pue  = reg_wr && (reg_addr == `OFS_PULLUP);
    assign wr_ods  = reg_wr && (reg_addr == `OFS_OPEN_DRAIN);
    assign wr_pfs  = reg_wr && (reg_addr == `OFS_PIN_FUNC);
    assign wr_mode = reg_wr && (reg_addr == `OFS_MODE);

    // masked write data: reserved bits stay at their reset value
    wire [7:0] wdata_impl;
    wire [7:0] wdata_pu;
    wire [7:0] wdata_od;

    assign wdata_impl = reg_wdata & IMPL_MASK;
    assign wdata_pu   = reg_wdata & pu_mask;
    assign wdata_od   = reg_wdata & od_mask;

    // mode write keeps only the two standby fields
    wire [1:0] wdata_mode;

    assign wdata_mode = {reg_wdata[`MODE_SW_STBY], reg_wdata[`MODE_HW_STBY]};

    // direction and output data
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            direction_bits_r   <= `RST_BYTE;
            output_data_bits_r <= `RST_BYTE;
        end
        else
        begin
            if (wr_dir)
                direction_bits_r <= wdata_impl;
            if (wr_dat)
                output_data_bits_r <= wdata_impl;
        end
    end

    // input buffer enable
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            input_buffer_enable_r <= `RST_BYTE;
        else if (wr_ibe)
            input_buffer_enable_r <= wdata_impl;
    end

    // pull-up enable, absent on ports without pull-ups
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pullup_enable_r <= `RST_BYTE;
        else if (wr_pue)
            pullup_enable_r <= wdata_pu;
    end

    // open-drain select, absent on ports without it
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            open_drain_select_r <= `RST_BYTE;
        else if (wr_ods)
            open_drain_select_r <= wdata_od;
    end

    // pin function select
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pin_function_select_r <= `RST_BYTE;
        else if (wr_pfs)
            pin_function_select_r <= wdata_impl;
    end

    // operating mode: hardware and software standby
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            mode_r <= `RST_MODE;
        else if (wr_mode)
            mode_r <= wdata_mode;
    end

    ////////////////////////////////////////////////////////////////////
    // per-pin logic

    wire [7:0] out_nxt;
    wire [7:0] oe_n_nxt;
    wire [7:0] pullup_nxt;
    wire [7:0] in_a_nxt;
    wire [7:0] in_b_nxt;
    wire [7:0] drives_nxt;

    genvar i;
    generate
        for (i = 0; i < `PAD_W; i = i + 1)
        begin : g_pin
            pad_pin_cell u_cell
            (
                .pin_in     (pad_in[i]),
                .ibe        (ibe_view[i]),
                .pue        (pue_view[i]),
                .ods        (ods_view[i]),
                .dir        (dir_view[i]),
                .dout       (dat_view[i]),
                .bus_oe     (bus_oe[i] & IMPL_MASK[i]),
                .bus_out    (bus_out[i]),
                .p1_oe      (periph1_oe[i] & IMPL_MASK[i]),
                .p1_out     (periph1_out[i]),
                .p2_oe      (periph2_oe[i] & IMPL_MASK[i]),
                .p2_out     (periph2_out[i]),
                .pfs        (pfs_view[i]),
                .hw_stby    (hw_stby_sel),
                .out_nxt    (out_nxt[i]),
                .oe_n_nxt   (oe_n_nxt[i]),
                .pullup_nxt (pullup_nxt[i]),
                .in_a_nxt   (in_a_nxt[i]),
                .in_b_nxt   (in_b_nxt[i]),
                .drives     (drives_nxt[i])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // registered pad outputs

    // pin drive and enable; unimplemented pins never drive
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            pad_out    <= `RST_BYTE;
            pad_oe_n   <= ~`RST_BYTE;
        end
        else
        begin
            pad_out    <= out_nxt & IMPL_MASK;
            pad_oe_n   <= oe_n_nxt | ~IMPL_MASK;
        end
    end

    // active source flag, open-drain release counted as driving
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pin_drives <= `RST_BYTE;
        else
            pin_drives <= drives_nxt & IMPL_MASK;
    end

    // pull-ups: off in reset and hardware standby, otherwise follow the bit only on input pins
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            pullup_on <= `RST_BYTE;
        else
            pullup_on <= pullup_nxt & pu_mask;
    end

    // gated inputs toward the peripherals
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            periph_in_a <= ~`RST_BYTE;
            periph_in_b <= ~`RST_BYTE;
        end
        else
        begin
            periph_in_a <= in_a_nxt | ~IMPL_MASK;
            periph_in_b <= in_b_nxt | ~IMPL_MASK;
        end
    end

    // standby status
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            hw_standby <= 1'b0;
            sw_standby <= 1'b0;
        end
        else
        begin
            hw_standby <= hw_stby_sel;
            sw_standby <= sw_stby_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register read

    // readback: output data on output pins, raw pin level otherwise
    wire [7:0] readback;

    generate
        for (i = 0; i < `PAD_W; i = i + 1)
        begin : g_readback
            assign readback[i] = dir_view[i] ? dat_view[i]
                                             : (pad_in[i] & IMPL_MASK[i]);
        end
    endgenerate

    reg  [7:0] rdata_nxt;

    // read mux; direction is write-only and unmapped reads give zero
    always @*
    begin
        rdata_nxt = `RST_BYTE;
        case (reg_addr)
            `OFS_DIRECTION:  rdata_nxt = `RST_BYTE;
            `OFS_OUT_DATA:   rdata_nxt = dat_view;
            `OFS_READBACK:   rdata_nxt = readback;
            `OFS_IBE:        rdata_nxt = ibe_view;
            `OFS_PULLUP:     rdata_nxt = pue_view;
            `OFS_OPEN_DRAIN: rdata_nxt = ods_view;
            `OFS_PIN_FUNC:   rdata_nxt = pfs_view;
            `OFS_MODE:       rdata_nxt = {6'h00, mode_r};
            default:         rdata_nxt = `RST_BYTE;
        endcase
    end

    // read data stands only in the cycle after the read strobe
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            reg_rdata <= `RST_BYTE;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= `RST_BYTE;
    end

endmodule

/* File: verif/pad_ctrl_chk_assertions.sv */
// checker for the port pad control: read slot, drive priority, pull-ups
`timescale 1ns/1ps
module pad_ctrl_chk
(
    input wire       sys_clk,
    input wire       rst,
    input wire       reg_rd,
    input wire       hw_standby,
    input wire [7:0] reg_rdata,
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe_n,
    input wire [7:0] pullup_on,
    input wire [7:0] pin_drives,
    input wire [7:0] bus_oe,
    input wire [7:0] bus_out,
    input wire [7:0] periph1_oe,
    input wire [7:0] periph1_out,
    input wire [7:0] periph2_oe,
    input wire [7:0] periph2_out,
    input wire [7:0] periph_in_a,
    input wire [7:0] periph_in_b
);
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
////////////////////////////////////////////////////////////////////////
property p_rd_zero;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
endproperty
a_rd_zero: assert property (p_rd_zero) else $error("read data outside slot");
property p_rst_vals;
    $past(rst) |-> pad_oe_n == 8'hff && pullup_on == 8'h00;
endproperty
a_rst_vals: assert property (p_rst_vals) else $error("pins not idle after reset");
property p_bus;
    ($past(bus_oe) & ~pad_oe_n & (pad_out ^ $past(bus_out))) == 8'h00
        && ($past(bus_oe) & ~$past(bus_out) & pad_oe_n) == 8'h00;
endproperty
a_bus: assert property (p_bus) else $error("bus drive lost");
property p_p1;
    ($past(periph1_oe & ~bus_oe) & ~pad_oe_n & (pad_out ^ $past(periph1_out))) == 8'h00;
endproperty
a_p1: assert property (p_p1) else $error("first peripheral drive lost");
property p_p2;
    ($past(periph2_oe & ~bus_oe & ~periph1_oe) & ~pad_oe_n
        & (pad_out ^ $past(periph2_out))) == 8'h00;
endproperty
a_p2: assert property (p_p2) else $error("second peripheral drive lost");
property p_pu_off;
    (pullup_on & (pin_drives | ~pad_oe_n)) == 8'h00;
endproperty
a_pu_off: assert property (p_pu_off) else $error("pull-up on a driven pin");
property p_hw;
    hw_standby && $past(hw_standby) |-> pullup_on == 8'h00;
endproperty
a_hw: assert property (p_hw) else $error("pull-up on in hardware standby");
property p_route;
    (periph_in_a | periph_in_b) == 8'hff;
endproperty
a_route: assert property (p_route) else $error("pin routed to both inputs");
endmodule
bind port_pad_buffer_control pad_ctrl_chk u_chk
(
    .sys_clk(sys_clk), .rst(rst), .reg_rd(reg_rd), .hw_standby(hw_standby),
    .reg_rdata(reg_rdata), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_on(pullup_on),
    .pin_drives(pin_drives), .bus_oe(bus_oe), .bus_out(bus_out), .periph1_oe(periph1_oe),
    .periph1_out(periph1_out), .periph2_oe(periph2_oe), .periph2_out(periph2_out),
    .periph_in_a(periph_in_a), .periph_in_b(periph_in_b)
);

/* File: verif/pin_world.sv */
// outside of the pins: external drivers, pull-ups and floating lines
`timescale 1ns/1ps
module pin_world
(
    input  wire       sys_clk,
    input  wire [7:0] pad_out,
    input  wire [7:0] pad_oe_n,
    input  wire [7:0] pullup_on,
    input  wire       ext_en,
    input  wire [7:0] ext_val,
    output wire [7:0] pad_in
);
reg [7:0] float_r = 8'h55;
// an undriven pin without pull-up wanders every cycle
always @(posedge sys_clk)
    float_r <= ~float_r;
// device drive first, then outside driver, then pull-up
assign pad_in = (~pad_oe_n & pad_out)
    | (pad_oe_n & (ext_en ? ext_val : (pullup_on | float_r)));
endmodule

/* File: verif/testbench.sv */
// self-checking bench for the port pad control
`timescale 1ns/1ps
module testbench;
logic       sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, ext_en = 1, pend = 0;
logic [3:0] reg_addr = 4'h0;
logic [7:0] reg_wdata = 0, bus_oe = 0, bus_out = 0, periph1_oe = 0, periph1_out = 0;
logic [7:0] periph2_oe = 0, periph2_out = 0, ext_val = 0, d, o, r, eo, ev;
wire  [7:0] reg_rdata, pad_in, pad_out, pad_oe_n, pullup_on, periph_in_a, periph_in_b;
wire  [7:0] pin_drives;
wire        hw_standby, sw_standby;
logic [7:0] exp_q[$];
int         err_count = 0, num_checks = 0;
port_pad_buffer_control uut
(
    .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_on(pullup_on), .bus_oe(bus_oe),
    .bus_out(bus_out), .periph1_oe(periph1_oe), .periph1_out(periph1_out),
    .periph2_oe(periph2_oe), .periph2_out(periph2_out), .periph_in_a(periph_in_a),
    .periph_in_b(periph_in_b), .pin_drives(pin_drives), .hw_standby(hw_standby),
    .sw_standby(sw_standby)
);
pin_world pins
(
    .sys_clk(sys_clk), .pad_out(pad_out), .pad_oe_n(pad_oe_n), .pullup_on(pullup_on),
    .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in)
);
always #2 sys_clk = ~sys_clk;
////////////////////////////////////////////////////////////////////////
function logic [7:0] rnd;
    return 8'($urandom);
endfunction
task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
        err_count++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
endtask
task wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
endtask
// a read notes its expected byte; the monitor compares it one cycle on
task rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    exp_q.push_back(e);
    @(posedge sys_clk);
    reg_rd <= 1'b0;
endtask
task settle;
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
endtask
task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
        $display("RESULT: PASS");
    else
        $display("RESULT: FAIL");
    $finish;
endtask
// read data monitor
always @(negedge sys_clk)
begin
    if (pend)
        chk(reg_rdata, exp_q.pop_front());
    pend = reg_rd;
end
// watchdog
initial
begin
    #20000;
    err_count++;
    wrap_up;
end
////////////////////////////////////////////////////////////////////////
initial
begin
    void'($urandom(55169));
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    settle;
    chk(pad_oe_n, 8'hff);
    chk(pullup_on, 8'h00);
    wr(4'hf, 8'hff);
    wr(4'h2, 8'hff);
    for (int a = 3; a < 6; a++)
        rd(4'(a), 8'h00);
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    rd(4'hf, 8'h00);
    for (int a = 3; a < 6; a++)
    begin
        r = rnd();
        wr(4'(a), r);
        rd(4'(a), r);
        wr(4'(a), 8'h00);
    end
    $display("test registers done");
    // buffer enable changes only while the peripheral inputs are idle
    r = rnd();
    @(posedge sys_clk);
    ext_val <= rnd();
    wr(4'h3, r);
    settle;
    chk(periph_in_a, ext_val | ~r);
    chk(periph_in_b, 8'hff);
    wr(4'h6, 8'hff);
    settle;
    chk(periph_in_b, ext_val | ~r);
    chk(periph_in_a, 8'hff);
    rd(4'h6, 8'hff);
    rd(4'h2, ext_val);
    $display("test input buffer done");
    d = rnd();
    o = rnd();
    wr(4'h0, d);
    wr(4'h1, o);
    settle;
    chk(pad_oe_n, ~d);
    chk(pad_out & d, o & d);
    rd(4'h2, d & o | ~d & ext_val);
    wr(4'h5, 8'hff);
    settle;
    chk(pad_oe_n, ~d | o);
    chk(pad_out & d, 8'h00);
    wr(4'h5, 8'h00);
    $display("test direction done");
    repeat (8)
    begin
        @(posedge sys_clk);
        bus_oe <= rnd() & rnd();
        bus_out <= rnd();
        periph1_oe <= rnd() & rnd();
        periph1_out <= rnd();
        periph2_oe <= rnd() & rnd();
        periph2_out <= rnd();
        settle;
        eo = ~(bus_oe | periph1_oe | periph2_oe | d);
        ev = bus_oe & bus_out | ~bus_oe & (periph1_oe & periph1_out
            | ~periph1_oe & (periph2_oe & periph2_out | ~periph2_oe & d & o));
        chk(pad_oe_n, eo);
        chk(pad_out & ~eo, ev);
        chk(pin_drives, ~eo);
    end
    @(posedge sys_clk);
    bus_oe <= 8'h00;
    periph1_oe <= 8'h00;
    periph2_oe <= 8'h00;
    ext_en <= 1'b0;
    $display("test priority done");
    wr(4'h4, 8'hff);
    settle;
    chk(pullup_on, ~d);
    rd(4'h2, d & o | ~d);
    wr(4'h7, 8'h02);
    settle;
    chk(pullup_on, ~d);
    chk({6'h00, sw_standby, hw_standby}, 8'h02);
    rd(4'h7, 8'h02);
    wr(4'h7, 8'h01);
    settle;
    chk(pullup_on, 8'h00);
    chk({6'h00, sw_standby, hw_standby}, 8'h01);
    wr(4'h7, 8'h00);
    settle;
    chk(pullup_on, ~d);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(negedge sys_clk);
    chk(pullup_on, 8'h00);
    @(posedge sys_clk);
    rst <= 1'b0;
    settle;
    chk(pullup_on, 8'h00);
    chk(pad_oe_n, 8'hff);
    chk({6'h00, sw_standby, hw_standby}, 8'h00);
    rd(4'h3, 8'h00);
    rd(4'h4, 8'h00);
    settle;
    $display("test pull-up done");
    wrap_up;
end
endmodule
